// ---- rtd_pkg.sv ----
// Package for the reader timer and p-driver configuration block.
// Assumes one 200 MHz clock and an 8-bit register port with one-cycle strobes.
package rtd_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_CW_P        = 8'h28;
   localparam logic [7:0] ADDR_MOD_P       = 8'h29;
   localparam logic [7:0] ADDR_TMODE       = 8'h2A;
   localparam logic [7:0] ADDR_PRESC_LO    = 8'h2B;
   localparam logic [7:0] ADDR_RELOAD_HI   = 8'h2C;
   localparam logic [7:0] ADDR_RELOAD_LO   = 8'h2D;
   localparam logic [7:0] ADDR_COUNT_HI    = 8'h2E;
   localparam logic [7:0] ADDR_COUNT_LO    = 8'h2F;
   localparam logic [7:0] ADDR_CONTROL     = 8'h40;
   localparam logic [7:0] ADDR_STATUS      = 8'h41;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h42;
   localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h43;
   localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h44;

   // Reset values
   localparam logic [5:0] RST_CW_P         = 6'h20;
   localparam logic [5:0] RST_MOD_P        = 6'h20;
   localparam logic [7:0] RST_TMODE        = 8'h00;
   localparam logic [7:0] RST_PRESC_LO     = 8'h00;
   localparam logic [15:0] RST_RELOAD      = 16'h0000;
   localparam logic [4:0] RST_CONTROL      = 5'h00;

   // Field positions in the timer mode register
   localparam int TMODE_PROTO_BIT   = 7;
   localparam int TMODE_GATE_HI     = 6;
   localparam int TMODE_GATE_LO     = 5;
   localparam int TMODE_RESTART_BIT = 4;
   localparam int TMODE_PRESC_HI    = 3;

   // Field positions in the control register
   localparam int CTRL_POWER_DOWN   = 0;
   localparam int CTRL_FULL_DEPTH   = 1;
   localparam int CTRL_PARITY       = 2;
   localparam int CTRL_MULTI_FRAME  = 3;
   localparam int CTRL_STOP_NOW     = 4;
   localparam int CTRL_START_NOW    = 5;

   // Conductance MSB forced in soft power-down
   localparam int COND_MSB          = 5;

   // Received bits after which the protocol stops the timer
   localparam logic [2:0] RX_STOP_BITS = 3'h5;

   // Reference rate made by a fractional accumulator
   localparam int REF_KHZ           = 13560;
   localparam int CLK_MHZ           = 200;
   localparam int CLK_KHZ           = CLK_MHZ * 1000;
   localparam logic [17:0] REF_STEP = 18'(REF_KHZ);
   localparam logic [17:0] ACC_WRAP = 18'(CLK_KHZ);

   typedef enum logic [1:0] {
      GATE_NONE,
      GATE_AUX_SERIAL,
      GATE_AUX_ONE,
      GATE_RESERVED
   } rtd_gate_e;

   typedef enum {
      TMR_IDLE,
      TMR_RUN
   } rtd_timer_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rtd_bus_req_s;

   typedef struct packed {
      logic [5:0] cw;
      logic [5:0] modul;
      logic [5:0] active;
   } rtd_drive_s;

endpackage

// ---- rtd_timer_cfg.sv ----
// Timer and p-driver conductance configuration of a contactless reader.
// Assumes protocol strobes on mclk; aux pins arrive asynchronously.

// Function
// - Six-bit CW p-driver conductance, upper bits reserved, resets to 0x20.
// - Soft power-down forces MSB of both p-driver conductances to one.
// - Separate six-bit modulation conductance used only while modulating, resets to 0x20.
// - Full-depth keying makes the modulation conductance setting ignored.
// - Protocol start bit starts the timer at every transmission end.
// - Without multi-frame receive, timer stops at the fifth received bit.
// - With multi-frame receive, only immediate stop or expiry without reload on zero halts the timer.
// - Protocol start bit zero: transmit and receive events do not affect timer.
// - Gate select 00 none, 01 aux serial input, 10 aux pin one.
// - In gated mode counting flag shows enabled timer, not gate level.
// - Reload on zero bit reloads the count and keeps counting.
// - Without reload on zero, count to zero then set expired flag.
// - Prescaler is mode bits 3..0 above the low prescale register.
// - Parity select zero: tick is reference over twice prescaler plus one.
// - Parity select one: tick is reference over twice prescaler plus two.
// - A start event loads the counter from the reload value, unless a stop event comes in the same cycle while running.
// - Reload writes do not touch a running count.
module rtd_timer_cfg (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire rtd_pkg::rtd_bus_req_s bus_req,
   output logic [7:0]                 rd_data,
   input  wire logic                  tx_end,
   input  wire logic                  rx_bit,
   input  wire logic                  modulating,
   input  wire logic                  aux_serial_input,
   input  wire logic                  aux_pin_one,
   output rtd_pkg::rtd_drive_s        p_drive,
   output logic                       counting_flag,
   output logic                       timer_expired_flag,
   output logic                       irq
);

   logic [5:0]          cw_p_conductance_reg;
   logic [5:0]          mod_p_conductance_reg;
   logic [7:0]          tmode_reg;
   logic [7:0]          prescale_low_reg;
   logic [15:0]         reload_value_reg;
   logic [3:0]          control_reg;
   logic                irq_status_reg;
   logic                irq_enable_reg;
   logic [15:0]         count_reg;
   logic [15:0]         count_next;
   rtd_pkg::rtd_timer_e state_reg;
   logic [2:0]          rx_count_reg;
   logic [17:0]         acc_reg;
   logic [18:0]         acc_sum;
   logic                ref_tick;
   logic [12:0]         presc_cnt_reg;
   logic [12:0]         presc_div;
   logic                timer_tick;
   logic [1:0]          aux_raw;
   wire logic [1:0]     aux_level;
   logic                gate_open;
   logic                wr_hit_ctrl;
   logic                start_event;
   logic                stop_event;
   logic                end_reached;
   logic                expire_event;
   logic [11:0]         prescale_value;
   logic [5:0]          cw_eff;
   logic [5:0]          mod_eff;

   function automatic logic wr_hit(input rtd_pkg::rtd_bus_req_s req, input logic [7:0] addr);
      wr_hit = req.wr && (req.addr == addr);
   endfunction

   function automatic logic [5:0] force_msb(input logic [5:0] value, input logic power_down);
      force_msb = value;
      if (power_down) begin
         force_msb[rtd_pkg::COND_MSB] = 1'b1;
      end
   endfunction

   // Configuration registers, one process each
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cw_p_conductance_reg <= rtd_pkg::RST_CW_P;
      end else if (wr_hit(bus_req, rtd_pkg::ADDR_CW_P)) begin
         cw_p_conductance_reg <= bus_req.wdata[5:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mod_p_conductance_reg <= rtd_pkg::RST_MOD_P;
      end else if (wr_hit(bus_req, rtd_pkg::ADDR_MOD_P)) begin
         mod_p_conductance_reg <= bus_req.wdata[5:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tmode_reg <= rtd_pkg::RST_TMODE;
      end else if (wr_hit(bus_req, rtd_pkg::ADDR_TMODE)) begin
         tmode_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prescale_low_reg <= rtd_pkg::RST_PRESC_LO;
      end else if (wr_hit(bus_req, rtd_pkg::ADDR_PRESC_LO)) begin
         prescale_low_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         control_reg <= rtd_pkg::RST_CONTROL[3:0];
      end else if (wr_hit_ctrl) begin
         control_reg <= bus_req.wdata[3:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_enable_reg <= 1'b0;
      end else if (wr_hit(bus_req, rtd_pkg::ADDR_IRQ_ENABLE)) begin
         irq_enable_reg <= bus_req.wdata[0];
      end
   end

   // Reload value; sampled at a start event and on reload at zero
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reload_value_reg <= rtd_pkg::RST_RELOAD;
      end else begin
         if (wr_hit(bus_req, rtd_pkg::ADDR_RELOAD_HI)) begin
            reload_value_reg[15:8] <= bus_req.wdata;
         end
         if (wr_hit(bus_req, rtd_pkg::ADDR_RELOAD_LO)) begin
            reload_value_reg[7:0] <= bus_req.wdata;
         end
      end
   end

   assign wr_hit_ctrl = wr_hit(bus_req, rtd_pkg::ADDR_CONTROL);

   // Conductance outputs
   always_comb begin
      cw_eff  = force_msb(cw_p_conductance_reg, control_reg[rtd_pkg::CTRL_POWER_DOWN]);
      mod_eff = force_msb(mod_p_conductance_reg, control_reg[rtd_pkg::CTRL_POWER_DOWN]);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         p_drive <= '0;
      end else begin
         p_drive.cw    <= cw_eff;
         p_drive.modul <= mod_eff;
         if (modulating && !control_reg[rtd_pkg::CTRL_FULL_DEPTH]) begin
            p_drive.active <= mod_eff;
         end else if (modulating) begin
            p_drive.active <= '0;
         end else begin
            p_drive.active <= cw_eff;
         end
      end
   end

   // Aux pin synchronisers, one per gate pin
   assign aux_raw = {aux_pin_one, aux_serial_input};

   for (genvar g = 0; g < 2; g++) begin : g_aux_sync
      logic [2:0] sync_reg;
      logic       level_reg;
      always_ff @(posedge mclk or negedge reset_n) begin
         if (!reset_n) begin
            sync_reg  <= '0;
            level_reg <= 1'b0;
         end else begin
            sync_reg <= {sync_reg[1:0], aux_raw[g]};
            if (sync_reg[1] == sync_reg[2]) begin
               level_reg <= sync_reg[2];
            end
         end
      end
      assign aux_level[g] = level_reg;
   end

   always_comb begin
      case (rtd_pkg::rtd_gate_e'(tmode_reg[rtd_pkg::TMODE_GATE_HI:rtd_pkg::TMODE_GATE_LO]))
         rtd_pkg::GATE_NONE:       gate_open = 1'b1;
         rtd_pkg::GATE_AUX_SERIAL: gate_open = aux_level[0];
         rtd_pkg::GATE_AUX_ONE:    gate_open = aux_level[1];
         default:                  gate_open = 1'b0;
      endcase
   end

   // Reference tick from the 200 MHz clock
   assign acc_sum  = {1'b0, acc_reg} + {1'b0, rtd_pkg::REF_STEP};
   assign ref_tick = acc_sum >= {1'b0, rtd_pkg::ACC_WRAP};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg <= '0;
      end else if (ref_tick) begin
         acc_reg <= 18'(acc_sum - {1'b0, rtd_pkg::ACC_WRAP});
      end else begin
         acc_reg <= acc_sum[17:0];
      end
   end

   // Prescaler divides by 2P+1 or 2P+2
   assign prescale_value = {tmode_reg[rtd_pkg::TMODE_PRESC_HI:0], prescale_low_reg};
   assign presc_div      = {prescale_value, control_reg[rtd_pkg::CTRL_PARITY]};
   assign timer_tick     = ref_tick && (presc_cnt_reg == presc_div);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         presc_cnt_reg <= '0;
      end else if (start_event || state_reg != rtd_pkg::TMR_RUN) begin
         presc_cnt_reg <= '0;
      end else if (timer_tick) begin
         presc_cnt_reg <= '0;
      end else if (ref_tick) begin
         presc_cnt_reg <= presc_cnt_reg + 13'h0001;
      end
   end

   // Start and stop events
   always_comb begin
      start_event = bus_req.wr && (bus_req.addr == rtd_pkg::ADDR_CONTROL)
                    && bus_req.wdata[rtd_pkg::CTRL_START_NOW];
      if (tmode_reg[rtd_pkg::TMODE_PROTO_BIT] && tx_end) begin
         start_event = 1'b1;
      end
      stop_event = wr_hit_ctrl && bus_req.wdata[rtd_pkg::CTRL_STOP_NOW];
      if (tmode_reg[rtd_pkg::TMODE_PROTO_BIT] && !control_reg[rtd_pkg::CTRL_MULTI_FRAME]
          && rx_bit && state_reg == rtd_pkg::TMR_RUN
          && rx_count_reg == rtd_pkg::RX_STOP_BITS - 3'h1) begin
         stop_event = 1'b1;
      end
   end

   // Received-bit counter since start
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_count_reg <= '0;
      end else if (start_event) begin
         rx_count_reg <= '0;
      end else if (rx_bit && state_reg == rtd_pkg::TMR_RUN && rx_count_reg != rtd_pkg::RX_STOP_BITS) begin
         rx_count_reg <= rx_count_reg + 3'h1;
      end
   end

   // Count-down
   assign end_reached  = (count_reg == 16'h0000) || (count_reg == 16'h0001);
   assign expire_event = state_reg == rtd_pkg::TMR_RUN && !start_event && !stop_event
                         && timer_tick && gate_open && end_reached;

   always_comb begin
      count_next = count_reg - 16'h0001;
      if (end_reached && tmode_reg[rtd_pkg::TMODE_RESTART_BIT]) begin
         count_next = reload_value_reg;
      end else if (end_reached) begin
         count_next = 16'h0000;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= rtd_pkg::TMR_IDLE;
         count_reg <= '0;
      end else begin
         case (state_reg)
            rtd_pkg::TMR_IDLE: begin
               if (start_event) begin
                  count_reg <= reload_value_reg;
                  state_reg <= rtd_pkg::TMR_RUN;
               end
            end
            rtd_pkg::TMR_RUN: begin
               if (stop_event) begin
                  state_reg <= rtd_pkg::TMR_IDLE;
               end else if (start_event) begin
                  count_reg <= reload_value_reg;
               end else if (timer_tick && gate_open) begin
                  count_reg <= count_next;
                  if (end_reached && !tmode_reg[rtd_pkg::TMODE_RESTART_BIT]) begin
                     state_reg <= rtd_pkg::TMR_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= rtd_pkg::TMR_IDLE;
            end
         endcase
      end
   end

   // Sticky expiry flag; set wins over clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_reg <= 1'b0;
      end else if (expire_event) begin
         irq_status_reg <= 1'b1;
      end else if (wr_hit(bus_req, rtd_pkg::ADDR_IRQ_CLEAR) && bus_req.wdata[0]) begin
         irq_status_reg <= 1'b0;
      end
   end

   assign counting_flag      = state_reg == rtd_pkg::TMR_RUN;
   assign timer_expired_flag = irq_status_reg;
   assign irq                = irq_status_reg && irq_enable_reg;

   // Read port, data one cycle after the strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            rtd_pkg::ADDR_CW_P:       rd_data <= {2'b00, cw_p_conductance_reg};
            rtd_pkg::ADDR_MOD_P:      rd_data <= {2'b00, mod_p_conductance_reg};
            rtd_pkg::ADDR_TMODE:      rd_data <= tmode_reg;
            rtd_pkg::ADDR_PRESC_LO:   rd_data <= prescale_low_reg;
            rtd_pkg::ADDR_RELOAD_HI:  rd_data <= reload_value_reg[15:8];
            rtd_pkg::ADDR_RELOAD_LO:  rd_data <= reload_value_reg[7:0];
            rtd_pkg::ADDR_COUNT_HI:   rd_data <= count_reg[15:8];
            rtd_pkg::ADDR_COUNT_LO:   rd_data <= count_reg[7:0];
            rtd_pkg::ADDR_CONTROL:    rd_data <= {4'h0, control_reg};
            rtd_pkg::ADDR_STATUS:     rd_data <= {7'h00, counting_flag};
            rtd_pkg::ADDR_IRQ_STATUS: rd_data <= {7'h00, irq_status_reg};
            rtd_pkg::ADDR_IRQ_ENABLE: rd_data <= {7'h00, irq_enable_reg};
            default:                  rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

endmodule

// ---- rtd_timer_cfg_assertions.sv ----
// Concurrent checks for the timer and p-driver configuration block.
// Assumes binding to rtd_timer_cfg; shadows only the register writes it needs.
module rtd_timer_cfg_assertions (
   input wire logic                  mclk,
   input wire logic                  reset_n,
   input wire rtd_pkg::rtd_bus_req_s bus_req,
   input wire logic [7:0]            rd_data,
   input wire logic                  tx_end,
   input wire logic                  rx_bit,
   input wire logic                  modulating,
   input wire logic                  aux_serial_input,
   input wire logic                  aux_pin_one,
   input wire rtd_pkg::rtd_drive_s   p_drive,
   input wire logic                  counting_flag,
   input wire logic                  timer_expired_flag,
   input wire logic                  irq
);
   logic [7:0] mode_q;
   logic       pd_q;
   logic       fd_q;
   logic       en_q;
   logic       wr_ctrl;
   logic       wr_clr;
   assign wr_ctrl = bus_req.wr && bus_req.addr == rtd_pkg::ADDR_CONTROL;
   assign wr_clr = bus_req.wr && bus_req.addr == rtd_pkg::ADDR_IRQ_CLEAR && bus_req.wdata[0];
   // Shadow copies of the written settings
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= 8'h00;
         pd_q <= 1'b0;
         fd_q <= 1'b0;
         en_q <= 1'b0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == rtd_pkg::ADDR_TMODE)
            mode_q <= bus_req.wdata;
         if (wr_ctrl) begin
            pd_q <= bus_req.wdata[0];
            fd_q <= bus_req.wdata[1];
         end
         if (bus_req.addr == rtd_pkg::ADDR_IRQ_ENABLE)
            en_q <= bus_req.wdata[0];
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   AST_READ_PULSE: assert property (!bus_req.rd |=> rd_data == 8'h00)
      else $error("read data outside read cycle");
   AST_RESERVED_BITS: assert property (bus_req.rd && bus_req.addr == rtd_pkg::ADDR_CW_P |=> rd_data[7:6] == 2'b00)
      else $error("reserved conductance bits read nonzero");
   AST_POWER_DOWN_FORCE: assert property (pd_q |=> p_drive.cw[5] && p_drive.modul[5])
      else $error("conductance msb not forced in power-down");
   AST_CW_WHEN_IDLE: assert property (!modulating |=> p_drive.active == p_drive.cw)
      else $error("active conductance not cw outside modulation");
   AST_MOD_WHEN_KEYING: assert property (modulating && !fd_q |=> p_drive.active == p_drive.modul)
      else $error("active conductance not mod during modulation");
   AST_FULL_DEPTH_ZERO: assert property (modulating && fd_q |=> p_drive.active == 6'h00)
      else $error("mod conductance used under full depth keying");
   AST_PROTO_START: assert property (tx_end && mode_q[7] && !rx_bit && !wr_ctrl |=> counting_flag)
      else $error("timer not started at transmission end");
   AST_PROTO_IGNORED: assert property (!counting_flag && !mode_q[7] && !wr_ctrl |=> !counting_flag)
      else $error("timer started without protocol start");
   AST_STOP_AT_END: assert property ($rose(timer_expired_flag) && !mode_q[4] |-> !counting_flag)
      else $error("timer kept running after expiry");
   AST_RELOAD_RUNS: assert property ($rose(timer_expired_flag) && mode_q[4] |-> counting_flag)
      else $error("timer stopped despite reload on zero");
   AST_FLAG_STICKY: assert property (timer_expired_flag && !wr_clr |=> timer_expired_flag)
      else $error("expired flag dropped without clear");
   AST_IRQ_ENABLED: assert property (timer_expired_flag && en_q |-> ##[0:1] irq)
      else $error("irq missing for enabled expiry");
   AST_IRQ_QUIET: assert property (!timer_expired_flag && !$past(timer_expired_flag) |-> !irq)
      else $error("irq without expiry");
   COV_EXPIRE: cover property ($rose(timer_expired_flag));
   COV_GATED: cover property (counting_flag && mode_q[6:5] != 2'b00);
   COV_POWER_DOWN: cover property (pd_q && modulating);
   COV_FULL_DEPTH: cover property (fd_q && modulating);
endmodule

bind rtd_timer_cfg rtd_timer_cfg_assertions i_chk (.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req),
   .rd_data(rd_data), .tx_end(tx_end), .rx_bit(rx_bit), .modulating(modulating),
   .aux_serial_input(aux_serial_input), .aux_pin_one(aux_pin_one), .p_drive(p_drive),
   .counting_flag(counting_flag), .timer_expired_flag(timer_expired_flag), .irq(irq));

// ---- tb_rtd_timer_cfg.sv ----
// Self-checking testbench for the timer and p-driver configuration block.
// Assumes a 200 MHz mclk and one-cycle register strobes.
module tb_rtd_timer_cfg;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  mclk;
   logic                  reset_n;
   rtd_pkg::rtd_bus_req_s bus_req;
   logic [7:0]            rd_data;
   logic                  tx_end;
   logic                  rx_bit;
   logic                  modulating;
   logic                  aux_serial_input;
   logic                  aux_pin_one;
   rtd_pkg::rtd_drive_s   p_drive;
   logic                  counting_flag;
   logic                  timer_expired_flag;
   logic                  irq;
   int                    n_mismatch;
   int                    checks;
   int                    t;

   rtd_timer_cfg i_dut (.mclk(mclk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
      .tx_end(tx_end), .rx_bit(rx_bit), .modulating(modulating), .aux_serial_input(aux_serial_input),
      .aux_pin_one(aux_pin_one), .p_drive(p_drive), .counting_flag(counting_flag),
      .timer_expired_flag(timer_expired_flag), .irq(irq));

   task automatic close_out();
      $display("Checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic rc(string name, logic [7:0] a, logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check(name, d, e);
   endtask

   // Pulse one protocol strobe, then let its edge land
   task automatic pulse(bit rx);
      @(posedge mclk);
      if (rx)
         rx_bit <= 1'b1;
      else
         tx_end <= 1'b1;
      @(posedge mclk);
      rx_bit <= 1'b0;
      tx_end <= 1'b0;
      #1;
   endtask

   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic wait_flag(output int n);
      #1;
      n = 0;
      while (timer_expired_flag !== 1'b1 && n < 9000) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic t_regs();
      rc("cw_rst", 8'h28, 8'h20);
      rc("mod_rst", 8'h29, 8'h20);
      rc("mode_rst", 8'h2A, 8'h00);
      rc("unmapped", 8'h30, 8'h00);
      wr(8'h28, 8'hFF);
      rc("cw_resv", 8'h28, 8'h3F);
   endtask

   task automatic t_drive();
      wr(8'h28, 8'h05);
      wr(8'h29, 8'h0A);
      wr(8'h40, 8'h01);
      settle();
      check("cw_pd", p_drive.cw, 6'h25);
      check("mod_pd", p_drive.modul, 6'h2A);
      wr(8'h40, 8'h00);
      modulating <= 1'b1;
      settle();
      check("act_mod", p_drive.active, 6'h0A);
      wr(8'h40, 8'h02);
      settle();
      check("act_fd", p_drive.active, 6'h00);
      @(posedge mclk);
      modulating <= 1'b0;
      settle();
      check("act_cw", p_drive.active, 6'h05);
      wr(8'h40, 8'h00);
   endtask

   task automatic t_proto();
      wr(8'h2C, 8'h10);
      wr(8'h2A, 8'h80);
      pulse(0);
      check("run_tx", counting_flag, 1'b1);
      repeat (4) pulse(1);
      check("run_4rx", counting_flag, 1'b1);
      pulse(1);
      check("stop_5rx", counting_flag, 1'b0);
      wr(8'h40, 8'h08);
      pulse(0);
      repeat (6) pulse(1);
      check("multi", counting_flag, 1'b1);
      wr(8'h40, 8'h18);
      #1;
      check("stop_now", counting_flag, 1'b0);
      wr(8'h2A, 8'h00);
      pulse(0);
      check("no_proto", counting_flag, 1'b0);
      wr(8'h40, 8'h20);
      repeat (5) pulse(1);
      check("rx_ignored", counting_flag, 1'b1);
      wr(8'h40, 8'h10);
   endtask

   task automatic t_reload();
      wr(8'h2C, 8'h02);
      wr(8'h40, 8'h20);
      wr(8'h2C, 8'h00);
      wr(8'h2D, 8'h03);
      repeat (40) @(posedge mclk);
      rc("cnt_hi", 8'h2E, 8'h01);
      wr(8'h43, 8'h01);
      wr(8'h40, 8'h20);
      wait_flag(t);
      check("t_short", t >= 25 && t <= 62, 1'b1);
      check("flag_set", timer_expired_flag, 1'b1);
      check("stopped", counting_flag, 1'b0);
      check("irq_on", irq, 1'b1);
      rc("cnt_zero", 8'h2F, 8'h00);
      rc("irq_stat", 8'h42, 8'h01);
      wr(8'h44, 8'h01);
      settle();
      check("irq_clr", irq, 1'b0);
      wr(8'h2A, 8'h10);
      wr(8'h43, 8'h00);
      wr(8'h40, 8'h20);
      wait_flag(t);
      settle();
      check("restart", counting_flag, 1'b1);
      check("irq_mask", irq, 1'b0);
      wr(8'h44, 8'h01);
      wait_flag(t);
      check("again", t >= 15 && t <= 62, 1'b1);
      wr(8'h40, 8'h10);
      wr(8'h44, 8'h01);
      wr(8'h2A, 8'h00);
   endtask

   task automatic presc(logic [7:0] m, logic [7:0] lo, logic [7:0] par, logic [7:0] cnt, int n);
      int lo_b;
      wr(8'h2A, m);
      wr(8'h2B, lo);
      wr(8'h2D, cnt);
      wr(8'h40, par | 8'h20);
      wait_flag(t);
      lo_b = (int'(cnt) * n - 1) * 200000 / 13560;
      check("period", t >= lo_b - 3 && t <= lo_b + 20, 1'b1);
      wr(8'h44, 8'h01);
   endtask

   task automatic gate(logic [7:0] m, logic s, logic o, logic mov);
      logic [7:0] a;
      logic [7:0] b;
      @(posedge mclk);
      aux_serial_input <= s;
      aux_pin_one <= o;
      wr(8'h2A, m);
      wr(8'h40, 8'h20);
      repeat (20) @(posedge mclk);
      rd(8'h2F, a);
      repeat (60) @(posedge mclk);
      rd(8'h2F, b);
      check("run_gated", counting_flag, 1'b1);
      check("moving", a !== b, mov);
      wr(8'h40, 8'h10);
   endtask

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      repeat (60000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end

   initial begin
      reset_n = 1'b0;
      bus_req = '0;
      tx_end = 1'b0;
      rx_bit = 1'b0;
      modulating = 1'b0;
      aux_serial_input = 1'b0;
      aux_pin_one = 1'b0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs();
      t_drive();
      t_proto();
      t_reload();
      presc(8'h01, 8'h00, 8'h00, 8'h01, 513);
      presc(8'h00, 8'h05, 8'h04, 8'h04, 12);
      wr(8'h2B, 8'h00);
      wr(8'h2C, 8'h02);
      wr(8'h2D, 8'h00);
      gate(8'h20, 1'b0, 1'b1, 1'b0);
      gate(8'h20, 1'b1, 1'b0, 1'b1);
      gate(8'h40, 1'b1, 1'b0, 1'b0);
      gate(8'h40, 1'b0, 1'b1, 1'b1);
      gate(8'h60, 1'b1, 1'b1, 1'b0);
      gate(8'h00, 1'b0, 1'b0, 1'b1);
      close_out();
   end
endmodule
